// ==== verilog/periph_irq_pkg.sv ====
// Purpose: Constants for the peripheral interrupt flag and enable bank
// Assumes: Byte-wide register port, one clock
// Notes: Register indices are local choices
package periph_irq_pkg;
   localparam logic [2:0] ADDR_FLAGS_ONE = 3'h0;
   localparam logic [2:0] ADDR_FLAGS_TWO = 3'h1;
   localparam logic [2:0] ADDR_ENABLES_ONE = 3'h2;
   localparam logic [2:0] ADDR_ENABLES_TWO = 3'h3;
   localparam logic [2:0] ADDR_GLOBAL_CTRL = 3'h4;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   localparam logic [7:0] PRIORITY_RESET = 8'h00;
   localparam logic [7:0] GLOBAL_RESET = 8'h00;
   // Writable masks of flags one and of the second-group registers
   localparam logic [7:0] FLAGS_ONE_WMASK = 8'hcf;
   localparam logic [7:0] TWO_IMPL_MASK = 8'h0f;
   // Bit positions of the global control register and of the flags one level bits
   localparam int GCTL_GLOBAL_EN = 7;
   localparam int GCTL_GROUP_EN = 6;
   localparam int GCTL_PRIO_LEVELS = 0;
   localparam int RX_FULL_BIT = 5;
   localparam int TX_EMPTY_BIT = 4;
endpackage

// ==== verilog/periph_irq_bank.sv ====
// Purpose: Peripheral interrupt flags, enables and combined request
// Assumes: Events are one-cycle pulses synchronous to REF_CLK, except receive full and transmit empty, which are levels
// Notes: Priority bits for each source come in on a plain port
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module periph_irq_bank
   import periph_irq_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Register port
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Peripheral events, first group, bit 7 down to 0
   input wire logic PARALLEL_PORT_ACCESS,
   input wire logic CONVERSION_DONE,
   input wire logic SERIAL_RX_FULL,
   input wire logic SERIAL_TX_EMPTY,
   input wire logic SYNC_SERIAL_DONE,
   input wire logic CAPCOMP_ONE_EVENT,
   input wire logic TIMER_TWO_MATCH,
   input wire logic TIMER_ONE_OVERFLOW,
   // Peripheral events, second group, bit 3 down to 0
   input wire logic BUS_COLLISION,
   input wire logic LOW_VOLTAGE,
   input wire logic TIMER_THREE_OVERFLOW,
   input wire logic CAPCOMP_TWO_EVENT,
   // Priority bits per source, 1 is high
   input wire logic [7:0] PRIORITY_ONE,
   input wire logic [3:0] PRIORITY_TWO,
   // Requests toward the processor
   output logic PERIPH_REQ,
   output logic IRQ_HIGH,
   output logic IRQ_LOW
);

   logic [7:0] flags_one_r;
   logic [7:0] flags_one_nxt;
   logic [3:0] flags_two_r;
   logic [3:0] flags_two_nxt;
   logic [7:0] enables_one_r;
   logic [3:0] enables_two_r;
   logic [7:0] global_ctrl_r;
   logic [7:0] rdata_r;
   logic periph_req_r;
   logic irq_high_r;
   logic irq_low_r;

   wire logic wr_flags_one = WR && (ADDR == ADDR_FLAGS_ONE);
   wire logic wr_flags_two = WR && (ADDR == ADDR_FLAGS_TWO);
   wire logic wr_enables_one = WR && (ADDR == ADDR_ENABLES_ONE);
   wire logic wr_enables_two = WR && (ADDR == ADDR_ENABLES_TWO);
   wire logic wr_global = WR && (ADDR == ADDR_GLOBAL_CTRL);

   wire logic [7:0] events_one = {PARALLEL_PORT_ACCESS, CONVERSION_DONE, 1'b0, 1'b0,
      SYNC_SERIAL_DONE, CAPCOMP_ONE_EVENT, TIMER_TWO_MATCH, TIMER_ONE_OVERFLOW};
   wire logic [3:0] events_two = {BUS_COLLISION, LOW_VOLTAGE, TIMER_THREE_OVERFLOW,
      CAPCOMP_TWO_EVENT};

   // Sticky flags: a set in the cycle of a clear wins
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_one
         if (i == RX_FULL_BIT || i == TX_EMPTY_BIT) begin : g_level
            assign flags_one_nxt[i] = 1'b0;
         end else begin : g_sticky
            assign flags_one_nxt[i] = events_one[i] ||
               ((wr_flags_one && FLAGS_ONE_WMASK[i]) ? WDATA[i] : flags_one_r[i]);
         end
      end
      for (i = 0; i < 4; i++) begin : g_two
         assign flags_two_nxt[i] = events_two[i] ||
            (wr_flags_two ? WDATA[i] : flags_two_r[i]);
      end
   endgenerate

   // Receive full and transmit empty follow the buffer state, not writable
   wire logic [7:0] flags_one_view = {flags_one_r[7:6], SERIAL_RX_FULL, SERIAL_TX_EMPTY,
      flags_one_r[3:0]};

   wire logic [7:0] pend_one = flags_one_view & enables_one_r;
   wire logic [3:0] pend_two = flags_two_r & enables_two_r;
   wire logic [7:0] high_one = pend_one & PRIORITY_ONE;
   wire logic [3:0] high_two = pend_two & PRIORITY_TWO;
   wire logic [7:0] low_one = pend_one & ~PRIORITY_ONE;
   wire logic [3:0] low_two = pend_two & ~PRIORITY_TWO;
   wire logic any_pend = (|pend_one) || (|pend_two);

   wire logic g_en = global_ctrl_r[GCTL_GLOBAL_EN];
   wire logic grp_en = global_ctrl_r[GCTL_GROUP_EN];
   wire logic prio_on = global_ctrl_r[GCTL_PRIO_LEVELS];

   // Without priorities both enables gate; with them, each level has its own
   wire logic req_compat = any_pend && grp_en && g_en;
   wire logic req_high = prio_on && g_en && ((|high_one) || (|high_two));
   wire logic req_low = prio_on && grp_en && ((|low_one) || (|low_two));
   wire logic high_nxt = prio_on ? req_high : req_compat;
   wire logic low_nxt = prio_on && req_low;

   wire logic [7:0] rdata_nxt =
      (ADDR == ADDR_FLAGS_ONE) ? flags_one_view :
      (ADDR == ADDR_FLAGS_TWO) ? {4'h0, flags_two_r} :
      (ADDR == ADDR_ENABLES_ONE) ? enables_one_r :
      (ADDR == ADDR_ENABLES_TWO) ? {4'h0, enables_two_r} :
      (ADDR == ADDR_GLOBAL_CTRL) ? global_ctrl_r : 8'h00;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         flags_one_r <= FLAGS_RESET;
         flags_two_r <= FLAGS_RESET[3:0];
         enables_one_r <= ENABLES_RESET;
         enables_two_r <= ENABLES_RESET[3:0];
         global_ctrl_r <= GLOBAL_RESET;
      end else begin
         flags_one_r <= flags_one_nxt;
         flags_two_r <= flags_two_nxt;
         if (wr_enables_one) begin
            enables_one_r <= WDATA;
         end
         if (wr_enables_two) begin
            enables_two_r <= WDATA[3:0] & TWO_IMPL_MASK[3:0];
         end
         if (wr_global) begin
            global_ctrl_r <= WDATA & 8'hc1;
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rdata_r <= 8'h00;
         periph_req_r <= 1'b0;
         irq_high_r <= 1'b0;
         irq_low_r <= 1'b0;
      end else begin
         rdata_r <= RD ? rdata_nxt : 8'h00;
         periph_req_r <= any_pend;
         irq_high_r <= high_nxt;
         irq_low_r <= low_nxt;
      end
   end

   assign RDATA = rdata_r;
   assign PERIPH_REQ = periph_req_r;
   assign IRQ_HIGH = irq_high_r;
   assign IRQ_LOW = irq_low_r;

endmodule

// ==== testbench/periph_events.sv ====
// Purpose: Peripheral event source model
// Assumes: Bench names the sources to fire
// Notes: Output follows fire one edge later
`timescale 1ns/1ns
module periph_events (
   input wire logic clk,
   input wire logic [11:0] fire,
   output logic [11:0] ev = 12'h000
);
   always @(posedge clk)
      ev <= fire;
endmodule

// ==== testbench/periph_irq_props.sv ====
// Purpose: Port checks of the bank
// Assumes: One clock, async high reset
// Notes: Bound below
`timescale 1ns/1ns
module periph_irq_props (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic RD,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] RDATA,
   input wire logic TIMER_ONE_OVERFLOW,
   input wire logic TIMER_TWO_MATCH,
   input wire logic BUS_COLLISION,
   input wire logic LOW_VOLTAGE,
   input wire logic PERIPH_REQ,
   input wire logic IRQ_HIGH,
   input wire logic IRQ_LOW
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   a_read_idle: assert property (!RD |=> RDATA == 8'h00) else $error("stray data");
   a_upper_zero: assert property (RD && ADDR[0] && !ADDR[2] |=> RDATA[7:4] == 4'h0)
      else $error("upper bits");
   a_tone_sets: assert property (TIMER_ONE_OVERFLOW ##1 RD && ADDR == 3'h0 |=> RDATA[0])
      else $error("tone flag");
   a_ttwo_sets: assert property (TIMER_TWO_MATCH ##1 RD && ADDR == 3'h0 |=> RDATA[1])
      else $error("ttwo flag");
   a_coll_sets: assert property (BUS_COLLISION ##1 RD && ADDR == 3'h1 |=> RDATA[3])
      else $error("coll flag");
   a_volt_sets: assert property (LOW_VOLTAGE ##1 RD && ADDR == 3'h1 |=> RDATA[2])
      else $error("volt flag");
   a_high_gated: assert property (IRQ_HIGH |-> PERIPH_REQ) else $error("high");
   a_low_gated: assert property (IRQ_LOW |-> PERIPH_REQ) else $error("low");
endmodule
bind periph_irq_bank periph_irq_props props_i (.*);

// ==== testbench/periph_irq_bank_tb.sv ====
// Purpose: Bench of the bank
// Assumes: Partner model drives events
// Notes: Rows are addr, write, readback
`timescale 1ns/1ns
module periph_irq_bank_tb;
   logic clk = 0, rst = 1, wr = 0, rd = 0, req, ih, il;
   logic [2:0] addr = 3'h0;
   logic [3:0] pr2 = 4'h0;
   logic [7:0] wd = 8'h00, pr1 = 8'h00, rdv, rdata;
   logic [11:0] fire = 12'h000, ev;
   logic [19:0] rows[9] = '{20'h0ffcf, 20'h1ff0f, 20'h2ffff, 20'h3ff0f, 20'h5ff00,
      20'h00000, 20'h10000, 20'h20000, 20'h30000};
   int fails = 0, cmp_count = 0, cyc = 0;
   always #5 clk = ~clk;
   periph_events pe (.clk(clk), .fire(fire), .ev(ev));
   periph_irq_bank dut (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd),
      .RDATA(rdata), .PARALLEL_PORT_ACCESS(ev[11]), .CONVERSION_DONE(ev[10]),
      .SERIAL_RX_FULL(ev[9]), .SERIAL_TX_EMPTY(ev[8]), .SYNC_SERIAL_DONE(ev[7]),
      .CAPCOMP_ONE_EVENT(ev[6]), .TIMER_TWO_MATCH(ev[5]), .TIMER_ONE_OVERFLOW(ev[4]),
      .BUS_COLLISION(ev[3]), .LOW_VOLTAGE(ev[2]), .TIMER_THREE_OVERFLOW(ev[1]),
      .CAPCOMP_TWO_EVENT(ev[0]), .PRIORITY_ONE(pr1), .PRIORITY_TWO(pr2),
      .PERIPH_REQ(req), .IRQ_HIGH(ih), .IRQ_LOW(il));
   task chk(string n, logic [7:0] s, e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task wrr(logic [2:0] a, logic [7:0] d);
      addr <= a;
      wd <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task rdr(logic [2:0] a);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 rdv = rdata;
      @(posedge clk);
   endtask
   task outs(logic [2:0] e);
      repeat (2) @(posedge clk);
      #1 chk("requests", {5'h00, req, ih, il}, {5'h00, e});
   endtask
   task pulse(logic [11:0] m);
      fire <= m;
      @(posedge clk);
      fire <= 12'h000;
      @(posedge clk);
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      foreach (rows[i]) begin
         wrr(rows[i][18:16], rows[i][15:8]);
         rdr(rows[i][18:16]);
         chk("readback", rdv, rows[i][7:0]);
      end
      pulse(12'hcf0);
      rdr(3'h0);
      chk("flags one", rdv, 8'hcf);
      pulse(12'h00f);
      rdr(3'h1);
      chk("flags two", rdv, 8'h0f);
      outs(3'h0);
      wrr(3'h2, 8'h01);
      outs(3'h4);
      wrr(3'h4, 8'hc0);
      outs(3'h6);
      wrr(3'h4, 8'h80);
      outs(3'h4);
      wrr(3'h4, 8'h41);
      outs(3'h5);
      pr1 <= 8'h01;
      wrr(3'h4, 8'h81);
      outs(3'h6);
      wrr(3'h0, 8'h00);
      outs(3'h0);
      pr2 <= 4'h4;
      wrr(3'h3, 8'h04);
      outs(3'h6);
      wrr(3'h1, 8'h00);
      outs(3'h0);
      fire <= 12'h300;
      repeat (2) @(posedge clk);
      rdr(3'h0);
      fire <= 12'h000;
      chk("levels", rdv, 8'h30);
      rst <= 1;
      @(posedge clk);
      rst <= 0;
      @(posedge clk);
      for (int a = 0; a < 5; a++) begin
         rdr(a[2:0]);
         chk("reset", rdv, 8'h00);
      end
      tally_and_finish;
   end
endmodule
